// ===== include/ddrcad_pkg.sv
// Package of constants and types for the DDR command/address decoder.
// What this block does
// - Chip select falls, clock low: header starts
// - Header is six bytes on six edges
// - Bytes arrive MSB first, bit n on line n
// - Header bit 47 high means read
// - Header bit 46 high selects register space
// - Header bit 45 high selects linear burst
// - Header bits 44..16 are address 31..3
// - Header bits 15..3 are ignored
// - Header bits 2..0 are address 2..0
// - Upper address picks eight-word half-page
// - Page crossing may add strobe latency
// - Row crossing may add strobe latency
// - Access timing starts after row bits captured
// - Linear reads interleave consecutive half-page fetches
// - Header sampled through two-flop synchronisers on each clock edge
// - Strobe driven during header shows refresh latency
// - Chip select high aborts and rearms
package ddrcad_pkg;

	// ==========================================================
	// Header layout
	// ==========================================================
	localparam int HDR_BITS = 48;
	localparam int HDR_BYTES = 6;
	localparam int BIT_DIR = 47;
	localparam int BIT_SPACE = 46;
	localparam int BIT_BURST = 45;
	localparam int ROW_MSB = 44;
	localparam int ROW_LSB = 16;
	localparam int LOW_MSB = 2;
	localparam int ADDR_BITS = 32;
	localparam int HALF_PAGE_LSB = 3;
	localparam int PAGE_LSB = 4;
	localparam logic [2:0] LAST_BYTE = 3'h5;
	localparam logic [2:0] ROW_DONE_BYTE = 3'h3;
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR = 2'b01,
		ST_BODY = 2'b11
	} ddrcad_state_e;

	typedef struct packed {
		logic rd;
		logic reg_space;
		logic linear;
		logic [ADDR_BITS-1:0] word_addr;
	} ddrcad_cmd_s;

endpackage

// ===== src/ddrcad_decoder.sv
// Command/address header decoder for a DDR octal pseudo-static RAM.
module ddrcad_decoder import ddrcad_pkg::*; #(
	parameter int ROW_WORD_BITS = 10
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_CS_N,
	input wire logic I_CK,
	input wire logic [7:0] I_DQ,
	input wire logic I_REFRESH_PENDING,
	input wire logic I_WORD_STEP,
	output logic O_RW_DATA_STROBE,
	output logic O_RW_DATA_STROBE_OE,
	output logic O_ROW_START,
	output logic O_CMD_VALID,
	output ddrcad_cmd_s O_CMD,
	output logic O_PAGE_CROSS,
	output logic O_ROW_CROSS,
	output logic O_FETCH_REQ,
	output logic [ADDR_BITS-HALF_PAGE_LSB-1:0] O_FETCH_HALF_PAGE,
	output logic O_BUSY
);

	// ==========================================================
	// Pin synchronisation and edge finding
	// ==========================================================
	logic [9:0] sync_w;
	logic cs_act_s, cs_n_s, ck_s;
	logic [7:0] dq_s;

	// Chip select is synchronised active high so that the chain's reset
	// value means deselected; otherwise reset would look like a fall.
	ddrcad_sync #(.WIDTH(10)) u_sync (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_async({~I_CS_N, I_CK, I_DQ}),
		.o_sync(sync_w)
	);
	assign {cs_act_s, ck_s, dq_s} = sync_w;
	assign cs_n_s = ~cs_act_s;

	logic cs_n_prev_q, ck_prev_q;
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cs_n_prev_q <= 1'b1;
			ck_prev_q <= 1'b0;
		end else begin
			cs_n_prev_q <= cs_n_s;
			ck_prev_q <= ck_s;
		end
	end

	// Data and clock share the same sync delay, so centred bytes are
	// still stable when the delayed clock edge is seen.
	wire start_w = cs_n_prev_q & ~cs_n_s & ~ck_s;
	wire ck_edge_w = ck_s ^ ck_prev_q;
	wire abort_w = cs_n_s;

	// ==========================================================
	// Header state machine
	// ==========================================================
	ddrcad_state_e state_q, state_d;
	logic [2:0] cnt_q;
	logic [HDR_BITS-9:0] hdr_q;
	wire in_hdr_w = (state_q == ST_HDR);
	wire take_w = in_hdr_w & ck_edge_w & ~abort_w;
	wire last_w = take_w & (cnt_q == LAST_BYTE);
	wire row_done_w = take_w & (cnt_q == ROW_DONE_BYTE);
	wire [HDR_BITS-1:0] hdr_full_w = {hdr_q, dq_s};

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_w) begin
					state_d = ST_HDR;
				end
			end
			ST_HDR: begin
				if (abort_w) begin
					state_d = ST_IDLE;
				end else if (last_w) begin
					state_d = ST_BODY;
				end
			end
			ST_BODY: begin
				if (abort_w) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			hdr_q <= '0;
		end else begin
			state_q <= state_d;
			if (start_w) begin
				cnt_q <= '0;
			end else if (take_w) begin
				cnt_q <= cnt_q + 3'h1;
				hdr_q <= hdr_full_w[HDR_BITS-9:0];
			end
		end
	end

	// ==========================================================
	// Decoded command
	// ==========================================================
	// Bits 15..3 are reserved and simply dropped here.
	wire [ADDR_BITS-1:0] addr_w = {hdr_full_w[ROW_MSB:ROW_LSB],
		hdr_full_w[LOW_MSB:0]};

	ddrcad_cmd_s cmd_q;
	logic valid_q, row_start_q;
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cmd_q <= '0;
			valid_q <= 1'b0;
			row_start_q <= 1'b0;
		end else begin
			valid_q <= last_w;
			row_start_q <= row_done_w;
			if (last_w) begin
				cmd_q.rd <= hdr_full_w[BIT_DIR];
				cmd_q.reg_space <= hdr_full_w[BIT_SPACE];
				cmd_q.linear <= hdr_full_w[BIT_BURST];
				cmd_q.word_addr <= addr_w;
			end
		end
	end

	// ==========================================================
	// Refresh latency indication on the strobe
	// ==========================================================
	logic rw_data_strobe_q, rw_data_strobe_oe_q;
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rw_data_strobe_q <= 1'b0;
			rw_data_strobe_oe_q <= 1'b0;
		end else begin
			rw_data_strobe_oe_q <= (state_d == ST_HDR);
			if (start_w) begin
				rw_data_strobe_q <= I_REFRESH_PENDING;
			end
		end
	end

	// ==========================================================
	// Burst address walk, page and row crossings
	// ==========================================================
	// The pointer starts at the decoded word and advances once per word
	// the datapath reports; wrapped bursts step it too without wrapping, but flag no crossings and no fetch after the one at header end.
	logic [ADDR_BITS-1:0] ptr_q;
	logic page_x_q, row_x_q, fetch_q;
	logic [ADDR_BITS-HALF_PAGE_LSB-1:0] fetch_hp_q;
	wire [ADDR_BITS-1:0] ptr_nx_w = ptr_q + 32'h1;
	wire step_w = (state_q == ST_BODY) & I_WORD_STEP & ~abort_w;
	wire lin_step_w = step_w & cmd_q.linear;
	wire page_hit_w = (ptr_nx_w[PAGE_LSB-1:0] == '0);
	wire row_hit_w = (ptr_nx_w[ROW_WORD_BITS-1:0] == '0);
	wire half_hit_w = (ptr_nx_w[HALF_PAGE_LSB-1:0] == '0);

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ptr_q <= '0;
			page_x_q <= 1'b0;
			row_x_q <= 1'b0;
			fetch_q <= 1'b0;
			fetch_hp_q <= '0;
		end else begin
			page_x_q <= lin_step_w & page_hit_w;
			row_x_q <= lin_step_w & row_hit_w;
			fetch_q <= last_w | (lin_step_w & half_hit_w);
			if (last_w) begin
				ptr_q <= addr_w;
				fetch_hp_q <= addr_w[ADDR_BITS-1:HALF_PAGE_LSB];
			end else if (step_w) begin
				ptr_q <= ptr_nx_w;
				if (cmd_q.linear & half_hit_w) begin
					// Always the half-page after the last one fetched,
					// so no half-page of a linear burst is skipped.
					fetch_hp_q <= fetch_hp_q + 29'h1;
				end
			end
		end
	end

	assign O_RW_DATA_STROBE = rw_data_strobe_q;
	assign O_RW_DATA_STROBE_OE = rw_data_strobe_oe_q;
	assign O_ROW_START = row_start_q;
	assign O_CMD_VALID = valid_q;
	assign O_CMD = cmd_q;
	assign O_PAGE_CROSS = page_x_q;
	assign O_ROW_CROSS = row_x_q;
	assign O_FETCH_REQ = fetch_q;
	assign O_FETCH_HALF_PAGE = fetch_hp_q;
	assign O_BUSY = (state_q != ST_IDLE);

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	sequence s_last_byte;
		in_hdr_w && ck_edge_w && !abort_w && cnt_q == LAST_BYTE;
	endsequence

	AST_START: assert property (start_w |=> state_q == ST_HDR)
		else $error("header did not start on chip select fall");
	AST_SIX: assert property (O_CMD_VALID |-> $past(cnt_q) == LAST_BYTE)
		else $error("command valid not after sixth byte");
	AST_DIR: assert property (s_last_byte |=> O_CMD.rd == $past(hdr_q[39]))
		else $error("direction bit decoded wrongly");
	AST_SPACE: assert property (s_last_byte |=>
		O_CMD.reg_space == $past(hdr_q[38]))
		else $error("space bit decoded wrongly");
	AST_BURST: assert property (s_last_byte |=>
		O_CMD.linear == $past(hdr_q[37]))
		else $error("burst type decoded wrongly");
	AST_ROW: assert property (s_last_byte |=>
		O_CMD.word_addr[31:3] == $past(hdr_q[36:8]))
		else $error("row address decoded wrongly");
	AST_LOW: assert property (s_last_byte |=>
		O_CMD.word_addr[2:0] == $past(dq_s[2:0]))
		else $error("lower column decoded wrongly");
	AST_ROWSTART: assert property (O_ROW_START |->
		$past(in_hdr_w && ck_edge_w && !abort_w && cnt_q == ROW_DONE_BYTE))
		else $error("row start pulse misplaced");
	AST_RW_DATA_STROBE: assert property (in_hdr_w |-> O_RW_DATA_STROBE_OE)
		else $error("strobe not driven during header");
	AST_ABORT: assert property (cs_n_s && O_BUSY |=> !O_BUSY)
		else $error("chip select high did not abort");
	AST_PULSE: assert property (O_CMD_VALID |=> !O_CMD_VALID)
		else $error("valid longer than one cycle");

endmodule // ddrcad_decoder

// ===== src/ddrcad_sync.sv
// Two-flop synchroniser for a group of pins from outside the clock domain.
module ddrcad_sync import ddrcad_pkg::*; #(
	parameter int WIDTH = 10
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// ==========================================================
	// One two-stage chain per bit
	// ==========================================================
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic [SYNC_STAGES-1:0] chain_q;
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					chain_q <= '0;
				end else begin
					chain_q <= {chain_q[SYNC_STAGES-2:0], i_async[g]};
				end
			end
			assign o_sync[g] = chain_q[SYNC_STAGES-1];
		end
	endgenerate

endmodule // ddrcad_sync

// ===== testbench/ddrcad_decoder_tb_top.sv
// Testbench for the command/address header decoder.
module ddrcad_decoder_tb_top import ddrcad_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic refresh = 1'b0;
	logic step = 1'b0;
	logic cs_n, ck, rw_data_strobe, oe, rstart, valid, pcross, rcross, busy;
	logic [7:0] dq, n_v = 8'h00, n_r = 8'h00, n_s = 8'h00, n_x = 8'h00;
	logic [7:0] n_f = 8'h00, n_b = 8'h00;
	logic fetch;
	logic [28:0] fhp;
	logic [15:0] bad_count = 16'h0000, n_checks = 16'h0000;
	logic [47:0] h;
	ddrcad_cmd_s cmd, exp;
	always #10 clk = ~clk;
	ddrcad_host_model u_ddrcad_host_model (.i_clk(clk), .o_cs_n(cs_n),
		.o_ck(ck), .o_dq(dq));
	ddrcad_decoder #(.ROW_WORD_BITS(5)) u_ddrcad_decoder (.I_CLK(clk),
		.I_RST(rst), .I_CS_N(cs_n), .I_CK(ck), .I_DQ(dq),
		.I_REFRESH_PENDING(refresh), .I_WORD_STEP(step), .O_RW_DATA_STROBE(rw_data_strobe),
		.O_RW_DATA_STROBE_OE(oe), .O_ROW_START(rstart), .O_CMD_VALID(valid),
		.O_CMD(cmd), .O_PAGE_CROSS(pcross), .O_ROW_CROSS(rcross),
		.O_FETCH_REQ(fetch), .O_FETCH_HALF_PAGE(fhp), .O_BUSY(busy));
	// ==========================
	// Pulse counters
	// ==========================
	always @(posedge clk) begin
		n_v <= n_v + 8'(valid === 1'b1);
		n_r <= n_r + 8'(rstart === 1'b1);
		n_s <= n_s + 8'(oe === 1'b1 && rw_data_strobe === 1'b1);
		n_x <= n_x + 8'(pcross === 1'b1) + 8'(rcross === 1'b1);
		n_f <= n_f + 8'(fetch === 1'b1);
		n_b <= n_b + 8'(busy === 1'b1);
	end
	// ==========================
	// Checks and frames
	// ==========================
	task automatic chk_num(input string nm, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_cmd(input ddrcad_cmd_s e);
		n_checks++;
		if (cmd !== e) begin
			bad_count++;
			$display("[FAIL] command expected %h seen %h", e, cmd);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks != 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Counts are compared as differences so the counters never need clearing.
	task automatic frame(input int ne, ns, input logic ckh,
		input logic [7:0] ev, er, ex, ef);
		logic [7:0] v, r, s, x, f;
		f = n_f;
		v = n_v;
		r = n_r;
		s = n_s;
		x = n_x;
		u_ddrcad_host_model.xfer(h, ne, ckh);
		repeat (ns) begin
			step = 1'b1;
			@(negedge clk);
			step = 1'b0;
			repeat (3) @(negedge clk);
		end
		u_ddrcad_host_model.finish();
		chk_num("cmd valid", ev, n_v - v);
		chk_num("row start", er, n_r - r);
		chk_num("strobe", {7'h0, refresh & ~ckh}, {7'h0, n_s != s});
		chk_num("crossings", ex, n_x - x);
		chk_num("fetches", ef, n_f - f);
		chk_num("busy", 8'h00, {7'h0, busy});
	endtask
	initial begin
		#300000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk_num("reset valid", 8'h00, {7'h0, valid});
		chk_num("reset busy", 8'h00, n_b);
		for (int k = 0; k < 8; k++) begin
			h = {k[2:0], 29'h0b5a1c3 ^ 29'(k), 13'h1fff, 3'(7 - k)};
			exp = '{h[47], h[46], h[45], {h[44:16], h[2:0]}};
			frame(6, 0, 1'b0, 8'h01, 8'h01, 8'h00, 8'h01);
			chk_cmd(exp);
		end
		refresh = 1'b1;
		frame(6, 0, 1'b0, 8'h01, 8'h01, 8'h00, 8'h01);
		refresh = 1'b0;
		frame(3, 0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00);
		chk_cmd(exp);
		frame(4, 0, 1'b0, 8'h00, 8'h01, 8'h00, 8'h00);
		frame(6, 0, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00);
		h = {3'b001, 29'h0000003, 13'h0000, 3'h6};
		frame(6, 2, 1'b0, 8'h01, 8'h01, 8'h02, 8'h02);
		chk_num("fetch half page", 8'(h[44:16] + 29'h1), fhp[7:0]);
		h[45] = 1'b0;
		frame(6, 2, 1'b0, 8'h01, 8'h01, 8'h00, 8'h01);
		tally_and_finish();
	end
endmodule // ddrcad_decoder_tb_top

// ===== testbench/ddrcad_host_model.sv
// Host bus controller model that drives chip select, clock and data lines.
module ddrcad_host_model (
	input wire logic i_clk,
	output logic o_cs_n,
	output logic o_ck,
	output logic [7:0] o_dq
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_cs_n = 1'b1;
		o_ck = 1'b0;
		o_dq = 8'ha5;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Bytes change mid half-period so each clock edge meets a settled byte.
	task automatic xfer(input logic [47:0] h, input int ne, input logic ckh);
		o_ck = ckh;
		wait_clk(4);
		o_cs_n = 1'b0;
		for (int i = 0; i < ne; i++) begin
			o_dq = h[47-8*i -: 8];
			wait_clk(2);
			o_ck = ~o_ck;
			wait_clk(2);
		end
		o_dq = ~o_dq;
		wait_clk(6);
	endtask
	task automatic finish();
		o_ck = 1'b0;
		o_cs_n = 1'b1;
		o_dq = ~o_dq;
		wait_clk(8);
	endtask
endmodule // ddrcad_host_model
